//--- include/fpec_pkg.sv
// Shared constants and types for the flash program/erase control block.
package fpec_pkg;

   // Register byte offsets on the Wishbone slave.
   localparam logic [7:0] OFF_MODE_ONE  = 8'h00;
   localparam logic [7:0] OFF_MODE_TWO  = 8'h04;
   localparam logic [7:0] OFF_BLK_ONE   = 8'h08;
   localparam logic [7:0] OFF_BLK_TWO   = 8'h0c;
   localparam logic [7:0] OFF_PROG_ADDR = 8'h10;
   localparam logic [7:0] OFF_STATUS    = 8'h14;

   // Field positions of flash_mode_control_one.
   localparam int BIT_PIN = 7;
   localparam int BIT_SWE = 6;
   localparam int BIT_EV  = 3;
   localparam int BIT_PV  = 2;
   localparam int BIT_E   = 1;
   localparam int BIT_P   = 0;

   // Field positions of flash_mode_control_two.
   localparam int BIT_ESU = 1;
   localparam int BIT_PSU = 0;

   // Field positions of the status register.
   localparam int STAT_ERASED_LSB = 0;
   localparam int STAT_OP_LSB     = 16;
   localparam int STAT_BOOT_LSB   = 24;

   // Reset values.
   localparam logic [7:0]  RST_MODE_ONE  = 8'h00;
   localparam logic [7:0]  RST_MODE_TWO  = 8'h00;
   localparam logic [3:0]  RST_BLK_ONE   = 4'h0;
   localparam logic [7:0]  RST_BLK_TWO   = 8'h00;
   localparam logic [17:0] RST_PROG_ADDR = 18'h00000;
   localparam logic [11:0] RST_ERASED    = 12'h000;

   // Array geometry: 256 kbytes, 128-byte programming units, twelve erase blocks.
   localparam int          FLASH_AW    = 18;
   localparam int          UNIT_AW     = 7;
   localparam int          NUM_BLOCKS  = 12;
   localparam logic [7:0]  ERASED_BYTE = 8'hff;

   // Erase block start addresses in ascending order; block i ends where block i+1 starts.
   localparam logic [17:0] BLK_BASE [NUM_BLOCKS] = '{
      18'h00000, 18'h01000, 18'h02000, 18'h03000, 18'h04000, 18'h0c000,
      18'h0d000, 18'h0e000, 18'h0f000, 18'h10000, 18'h20000, 18'h30000};

   // At most one flash operation is active at a time; FPEC_IDLE means none.
   typedef enum logic [4:0] {
      FPEC_IDLE  = 5'h01,
      FPEC_PROG  = 5'h02,
      FPEC_PVER  = 5'h04,
      FPEC_ERASE = 5'h08,
      FPEC_EVER  = 5'h10
   } fpec_op_t;

   typedef enum logic [3:0] {
      BOOT_OFF   = 4'h1,
      BOOT_CHECK = 4'h2,
      BOOT_COPY  = 4'h4,
      BOOT_DONE  = 4'h8
   } fpec_boot_t;

endpackage

//--- include/fpec_blk_if.sv
// Address-to-erase-block lookup carried between the controller and the decoder.
`timescale 1ns/1ps
interface fpec_blk_if;
   import fpec_pkg::*;
   logic [FLASH_AW-1:0]   prog_addr;
   logic [FLASH_AW-1:0]   rd_addr;
   logic [NUM_BLOCKS-1:0] prog_blk;
   logic [NUM_BLOCKS-1:0] rd_blk;

   modport ctrl (output prog_addr, output rd_addr, input prog_blk, input rd_blk);
   modport dec  (input prog_addr, input rd_addr, output prog_blk, output rd_blk);
endinterface

//--- rtl/fpec_blkdec.sv
// Decodes flash byte addresses into one-hot erase block selects.
`timescale 1ns/1ps
module fpec_blkdec (
   fpec_blk_if.dec b
);
   import fpec_pkg::*;

   genvar i;
   generate
      for (i = 0; i < NUM_BLOCKS; i++) begin : g_blk
         if (i == NUM_BLOCKS - 1) begin : g_last
            assign b.prog_blk[i] = (b.prog_addr >= BLK_BASE[i]);
            assign b.rd_blk[i]   = (b.rd_addr >= BLK_BASE[i]);
         end else begin : g_mid
            assign b.prog_blk[i] = (b.prog_addr >= BLK_BASE[i]) && (b.prog_addr < BLK_BASE[i+1]);
            assign b.rd_blk[i]   = (b.rd_addr >= BLK_BASE[i]) && (b.rd_addr < BLK_BASE[i+1]);
         end
      end
   endgenerate

endmodule

//--- rtl/fpec_top.sv
// Flash program/erase controller with its Wishbone register file and boot sequencer.
`timescale 1ns/1ps
module fpec_top (
   input  wire logic                           REF_CLK,
   input  wire logic                           RST_N,
   input  wire logic                           WB_CYC_I,
   input  wire logic                           WB_STB_I,
   input  wire logic                           WB_WE_I,
   input  wire logic [3:0]                     WB_SEL_I,
   input  wire logic [7:0]                     WB_ADR_I,
   input  wire logic [31:0]                    WB_DAT_I,
   output logic      [31:0]                    WB_DAT_O,
   output logic                                WB_ACK_O,
   input  wire logic                           WRITE_ENABLE_PIN,
   input  wire logic                           FLASH_REG_ACCESS_ENABLE,
   input  wire logic                           LOW_POWER_ENTRY,
   input  wire logic                           BOOT_MODE,
   input  wire logic                           SERIAL_COMM_OK,
   input  wire logic                           BOOT_COPY_DONE,
   output logic                                BOOT_COPY_REQ,
   output logic                                FLASH_PROGRAM,
   output logic                                FLASH_PROGRAM_VERIFY,
   output logic                                FLASH_ERASE,
   output logic                                FLASH_ERASE_VERIFY,
   output logic      [fpec_pkg::NUM_BLOCKS-1:0] FLASH_ERASE_BLOCKS,
   output logic      [fpec_pkg::FLASH_AW-1:0]   FLASH_UNIT_ADDR,
   input  wire logic [fpec_pkg::FLASH_AW-1:0]   ARRAY_RD_ADDR,
   input  wire logic [7:0]                     ARRAY_RD_DATA,
   output logic      [7:0]                     READ_DATA
);
   import fpec_pkg::*;

   fpec_blk_if blk ();

   fpec_blkdec u_dec (
      .b (blk.dec)
   );

   // Register state.
   logic                  pin;
   logic                  software_write_enable;
   logic [3:0]            mode;
   logic                  erase_setup_bit;
   logic                  program_setup_bit;
   logic [3:0]            blk_one;
   logic [7:0]            blk_two;
   logic [FLASH_AW-1:0]   prog_addr;
   logic [NUM_BLOCKS-1:0] erased;
   logic [NUM_BLOCKS-1:0] erase_blocks;
   logic [7:0]            read_data;
   fpec_op_t              op;
   fpec_boot_t            boot;
   logic                  copy_req;
   logic                  ack;
   logic [31:0]           dat;

   logic                  next_pin;
   logic                  next_swe;
   logic [3:0]            next_mode;
   logic                  next_esu;
   logic                  next_psu;
   logic [3:0]            next_blk_one;
   logic [7:0]            next_blk_two;
   logic [FLASH_AW-1:0]   next_prog_addr;
   logic [NUM_BLOCKS-1:0] next_erased;
   logic [NUM_BLOCKS-1:0] next_erase_blocks;
   logic [7:0]            next_read_data;
   fpec_op_t              next_op;
   fpec_boot_t            next_boot;
   logic                  next_copy_req;
   logic                  next_ack;
   logic [31:0]           next_dat;

   // Bus decode.
   logic        req;
   logic        commit;
   logic        flash_reg;
   logic        gate_ok;
   logic [7:0]  wd;
   logic [7:0]  mode_one_rd;
   logic [31:0] rdata;
   logic        set_ok;

   assign req       = WB_CYC_I && WB_STB_I;
   assign commit    = req && ack && WB_WE_I;
   assign flash_reg = (WB_ADR_I == OFF_MODE_ONE) || (WB_ADR_I == OFF_MODE_TWO) ||
                      (WB_ADR_I == OFF_BLK_ONE) || (WB_ADR_I == OFF_BLK_TWO);
   assign gate_ok   = FLASH_REG_ACCESS_ENABLE || !flash_reg;
   assign wd        = WB_DAT_I[7:0];

   // A new mode bit is only accepted from the idle register state, one at a time.
   assign set_ok = software_write_enable && (mode == 4'h0) && ($countones(wd[3:0]) == 1);

   always_comb begin
      mode_one_rd          = 8'h00;
      mode_one_rd[BIT_PIN] = pin;
      mode_one_rd[BIT_SWE] = pin && software_write_enable;
      mode_one_rd[3:0]     = mode;
   end

   assign blk.prog_addr = prog_addr;
   assign blk.rd_addr   = ARRAY_RD_ADDR;

   // Read data mux; the flash registers read as zero while access is disabled.
   always_comb begin
      rdata = 32'h00000000;
      if (gate_ok) begin
         case (WB_ADR_I)
            OFF_MODE_ONE: begin
               rdata[7:0] = mode_one_rd;
            end
            OFF_MODE_TWO: begin
               rdata[BIT_ESU] = erase_setup_bit;
               rdata[BIT_PSU] = program_setup_bit;
            end
            OFF_BLK_ONE: begin
               rdata[3:0] = blk_one;
            end
            OFF_BLK_TWO: begin
               rdata[7:0] = blk_two;
            end
            OFF_PROG_ADDR: begin
               rdata[FLASH_AW-1:0] = prog_addr;
            end
            OFF_STATUS: begin
               rdata[STAT_ERASED_LSB +: NUM_BLOCKS] = erased;
               rdata[STAT_OP_LSB +: 5]              = op;
               rdata[STAT_BOOT_LSB +: 4]            = boot;
            end
            default: begin
               rdata = 32'h00000000;
            end
         endcase
      end
   end

   // Wishbone handshake: ack one cycle after the request, write at the acked edge.
   always_comb begin
      next_ack = req && !ack;
      next_dat = (req && !ack) ? rdata : dat;
   end

   // Register file updates.
   always_comb begin
      next_pin       = WRITE_ENABLE_PIN;
      next_swe       = software_write_enable;
      next_mode      = mode;
      next_esu       = erase_setup_bit;
      next_psu       = program_setup_bit;
      next_blk_one   = blk_one;
      next_blk_two   = blk_two;
      next_prog_addr = prog_addr;
      if (commit && gate_ok) begin
         case (WB_ADR_I)
            OFF_MODE_ONE: begin
               if (WB_SEL_I[0]) begin
                  if (pin) begin
                     next_swe = wd[BIT_SWE];
                  end
                  next_mode[BIT_EV] = wd[BIT_EV] && (mode[BIT_EV] || set_ok);
                  next_mode[BIT_PV] = wd[BIT_PV] && (mode[BIT_PV] || set_ok);
                  next_mode[BIT_E]  = wd[BIT_E] && (mode[BIT_E] || (set_ok && erase_setup_bit));
                  next_mode[BIT_P]  = wd[BIT_P] && (mode[BIT_P] || (set_ok && program_setup_bit));
               end
            end
            OFF_MODE_TWO: begin
               if (WB_SEL_I[0]) begin
                  next_esu = wd[BIT_ESU] && (erase_setup_bit || software_write_enable);
                  next_psu = wd[BIT_PSU] && (program_setup_bit || software_write_enable);
               end
            end
            OFF_BLK_ONE: begin
               if (WB_SEL_I[0]) begin
                  next_blk_one = wd[3:0];
               end
            end
            OFF_BLK_TWO: begin
               if (WB_SEL_I[0]) begin
                  next_blk_two = wd & (blk_two | {8{software_write_enable}});
               end
            end
            OFF_PROG_ADDR: begin
               // The unit offset bits are held at zero so every unit starts on 0x00 or 0x80.
               if (WB_SEL_I[0]) begin
                  next_prog_addr[7:UNIT_AW] = WB_DAT_I[7:UNIT_AW];
               end
               if (WB_SEL_I[1]) begin
                  next_prog_addr[15:8] = WB_DAT_I[15:8];
               end
               if (WB_SEL_I[2]) begin
                  next_prog_addr[17:16] = WB_DAT_I[17:16];
               end
            end
            default: begin
               next_swe = software_write_enable;
            end
         endcase
      end
      // More than one selected block is a setting error and clears every select.
      if ($countones({next_blk_one, next_blk_two}) > 1) begin
         next_blk_one = RST_BLK_ONE;
         next_blk_two = RST_BLK_TWO;
      end
      if (!software_write_enable) begin
         next_esu     = 1'b0;
         next_psu     = 1'b0;
         next_blk_one = RST_BLK_ONE;
         next_blk_two = RST_BLK_TWO;
      end
      if (LOW_POWER_ENTRY) begin
         next_swe     = RST_MODE_ONE[BIT_SWE];
         next_mode    = RST_MODE_ONE[3:0];
         next_esu     = RST_MODE_TWO[BIT_ESU];
         next_psu     = RST_MODE_TWO[BIT_PSU];
         next_blk_one = RST_BLK_ONE;
         next_blk_two = RST_BLK_TWO;
      end
   end

   // Operation sequencer. The pin and the software enable both have to be up;
   // clearing either one drops the array back to idle at once.
   always_comb begin
      next_op = FPEC_IDLE;
      if (pin && software_write_enable) begin
         if (mode[BIT_EV]) begin
            next_op = FPEC_EVER;
         end else if (mode[BIT_PV]) begin
            next_op = FPEC_PVER;
         end else if (mode[BIT_E]) begin
            next_op = FPEC_ERASE;
         end else if (mode[BIT_P]) begin
            next_op = FPEC_PROG;
         end else begin
            next_op = FPEC_IDLE;
         end
      end
   end

   // Erase targets and the erased-block tracker that serves the read path.
   always_comb begin
      if (boot != BOOT_OFF) begin
         next_erase_blocks = {NUM_BLOCKS{1'b1}};
      end else begin
         next_erase_blocks = {blk_one, blk_two};
      end
      next_erased = erased;
      // Programming a block dirties it; an erase finishing in the same cycle still wins.
      if (op != FPEC_PROG && next_op == FPEC_PROG) begin
         next_erased = next_erased & ~blk.prog_blk;
      end
      if (op == FPEC_ERASE && next_op != FPEC_ERASE) begin
         next_erased = next_erased | erase_blocks;
      end
      next_read_data = (|(erased & blk.rd_blk)) ? ERASED_BYTE : ARRAY_RD_DATA;
   end

   // Boot sequencer: link check first, then the erase routine copy into RAM.
   always_comb begin
      next_boot = boot;
      case (boot)
         BOOT_OFF: begin
            if (BOOT_MODE) begin
               next_boot = BOOT_CHECK;
            end
         end
         BOOT_CHECK: begin
            if (SERIAL_COMM_OK) begin
               next_boot = BOOT_COPY;
            end
         end
         BOOT_COPY: begin
            if (BOOT_COPY_DONE) begin
               next_boot = BOOT_DONE;
            end
         end
         BOOT_DONE: begin
            next_boot = BOOT_DONE;
         end
         default: begin
            next_boot = BOOT_OFF;
         end
      endcase
      if (!BOOT_MODE) begin
         next_boot = BOOT_OFF;
      end
      next_copy_req = (next_boot == BOOT_COPY);
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pin          <= RST_MODE_ONE[BIT_PIN];
         software_write_enable          <= RST_MODE_ONE[BIT_SWE];
         mode         <= RST_MODE_ONE[3:0];
         erase_setup_bit          <= RST_MODE_TWO[BIT_ESU];
         program_setup_bit          <= RST_MODE_TWO[BIT_PSU];
         blk_one      <= RST_BLK_ONE;
         blk_two      <= RST_BLK_TWO;
         prog_addr    <= RST_PROG_ADDR;
         erased       <= RST_ERASED;
         erase_blocks <= {NUM_BLOCKS{1'b0}};
         read_data    <= 8'h00;
         op           <= FPEC_IDLE;
         boot         <= BOOT_OFF;
         copy_req     <= 1'b0;
         ack          <= 1'b0;
         dat          <= 32'h00000000;
      end else begin
         pin          <= next_pin;
         software_write_enable          <= next_swe;
         mode         <= next_mode;
         erase_setup_bit          <= next_esu;
         program_setup_bit          <= next_psu;
         blk_one      <= next_blk_one;
         blk_two      <= next_blk_two;
         prog_addr    <= next_prog_addr;
         erased       <= next_erased;
         erase_blocks <= next_erase_blocks;
         read_data    <= next_read_data;
         op           <= next_op;
         boot         <= next_boot;
         copy_req     <= next_copy_req;
         ack          <= next_ack;
         dat          <= next_dat;
      end
   end

   assign WB_ACK_O             = ack;
   assign WB_DAT_O             = dat;
   assign BOOT_COPY_REQ        = copy_req;
   assign FLASH_PROGRAM        = (op == FPEC_PROG);
   assign FLASH_PROGRAM_VERIFY = (op == FPEC_PVER);
   assign FLASH_ERASE          = (op == FPEC_ERASE);
   assign FLASH_ERASE_VERIFY   = (op == FPEC_EVER);
   assign FLASH_ERASE_BLOCKS   = erase_blocks;
   assign FLASH_UNIT_ADDR      = prog_addr;
   assign READ_DATA            = read_data;

endmodule

//--- tb/fpec_top_sva.sv
// Port-level assertions for the flash program/erase controller.
`timescale 1ns/1ps
module fpec_top_sva (
   input wire logic                            REF_CLK,
   input wire logic                            RST_N,
   input wire logic                            WB_CYC_I,
   input wire logic                            WB_STB_I,
   input wire logic                            WB_WE_I,
   input wire logic [7:0]                      WB_ADR_I,
   input wire logic [31:0]                     WB_DAT_O,
   input wire logic                            WB_ACK_O,
   input wire logic                            WRITE_ENABLE_PIN,
   input wire logic                            FLASH_REG_ACCESS_ENABLE,
   input wire logic                            LOW_POWER_ENTRY,
   input wire logic                            BOOT_COPY_DONE,
   input wire logic                            BOOT_COPY_REQ,
   input wire logic                            FLASH_PROGRAM,
   input wire logic                            FLASH_PROGRAM_VERIFY,
   input wire logic                            FLASH_ERASE,
   input wire logic                            FLASH_ERASE_VERIFY,
   input wire logic [fpec_pkg::NUM_BLOCKS-1:0] FLASH_ERASE_BLOCKS,
   input wire logic [fpec_pkg::FLASH_AW-1:0]   FLASH_UNIT_ADDR
);
   import fpec_pkg::*;
   logic       req;
   logic       rd_one;
   logic [3:0] ops;
   assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign rd_one = req & ~WB_WE_I & (WB_ADR_I == 8'h00);
   assign ops = {FLASH_ERASE_VERIFY, FLASH_PROGRAM_VERIFY, FLASH_ERASE, FLASH_PROGRAM};
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   a_ack_next: assert property (req |=> WB_ACK_O)
      else $error("ack did not follow a request");
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack stayed high");
   a_op_exclusive: assert property ($onehot0(ops))
      else $error("more than one flash operation active");
   a_pin_blocks: assert property (!WRITE_ENABLE_PIN [*3] |=> ops == 4'h0)
      else $error("operation active with the write-enable pin low");
   a_unit_aligned: assert property (FLASH_UNIT_ADDR[6:0] == 7'h00)
      else $error("programming unit address not aligned");
   a_gated_read: assert property (req & ~WB_WE_I & ~FLASH_REG_ACCESS_ENABLE & (WB_ADR_I < 8'h10)
      |=> WB_DAT_O == 32'h00000000)
      else $error("gated register read returned data");
   a_reserved_zero: assert property (rd_one |=> WB_DAT_O[5:4] == 2'b00)
      else $error("reserved control bits read as one");
   a_low_power_idle: assert property (LOW_POWER_ENTRY [*2] |=> ops == 4'h0)
      else $error("operation active in low-power mode");
   a_pin_mirror: assert property (WRITE_ENABLE_PIN [*3] ##0 (rd_one & FLASH_REG_ACCESS_ENABLE)
      |=> WB_DAT_O[7])
      else $error("pin bit does not follow the pin");
   a_boot_all_blocks: assert property (BOOT_COPY_REQ && $past(BOOT_COPY_REQ)
      |-> FLASH_ERASE_BLOCKS == {NUM_BLOCKS{1'b1}})
      else $error("boot erase does not cover every block");
   a_copy_end: assert property (BOOT_COPY_DONE && BOOT_COPY_REQ |=> !BOOT_COPY_REQ)
      else $error("copy request held after copy done");
endmodule

bind fpec_top fpec_top_sva fpec_top_sva_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .WRITE_ENABLE_PIN(WRITE_ENABLE_PIN), .FLASH_REG_ACCESS_ENABLE(FLASH_REG_ACCESS_ENABLE),
   .LOW_POWER_ENTRY(LOW_POWER_ENTRY), .BOOT_COPY_DONE(BOOT_COPY_DONE), .BOOT_COPY_REQ(BOOT_COPY_REQ),
   .FLASH_PROGRAM(FLASH_PROGRAM), .FLASH_PROGRAM_VERIFY(FLASH_PROGRAM_VERIFY), .FLASH_ERASE(FLASH_ERASE),
   .FLASH_ERASE_VERIFY(FLASH_ERASE_VERIFY), .FLASH_ERASE_BLOCKS(FLASH_ERASE_BLOCKS),
   .FLASH_UNIT_ADDR(FLASH_UNIT_ADDR));

//--- tb/tb_fpec_top.sv
// Self-checking testbench for the flash program/erase controller.
`timescale 1ns/1ps
module tb_fpec_top;
   import fpec_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [3:0]  wb_sel = 4'h0;
   logic [7:0]  wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] dat_o;
   logic        ack;
   logic        pin = 1'b0;
   logic        acc_en = 1'b1;
   logic        low_pwr = 1'b0;
   logic        boot = 1'b0;
   logic        comm_ok = 1'b0;
   logic        copy_done = 1'b0;
   logic        copy_req;
   logic [3:0]  ops;
   logic [11:0] blocks;
   logic [17:0] unit_addr;
   logic [17:0] rd_addr = 18'h0;
   logic [7:0]  rd_data = 8'h5a;
   logic [7:0]  read_data;
   logic [31:0] rdat;
   logic [7:0]  modes [4] = '{8'h42, 8'h48, 8'h44, 8'h41};
   logic [17:0] probe [4] = '{18'h01000, 18'h01fff, 18'h00fff, 18'h02000};
   logic [7:0]  seen [4] = '{8'hff, 8'hff, 8'h5a, 8'h5a};
   int          fail_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic        prog;
   logic        pver;
   logic        ers;
   logic        ever;

   always #20 ref_clk = ~ref_clk;
   assign ops = {ever, pver, ers, prog};

   fpec_top fpec_top_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
      .WB_WE_I(wb_we), .WB_SEL_I(wb_sel), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .WRITE_ENABLE_PIN(pin), .FLASH_REG_ACCESS_ENABLE(acc_en), .LOW_POWER_ENTRY(low_pwr),
      .BOOT_MODE(boot), .SERIAL_COMM_OK(comm_ok), .BOOT_COPY_DONE(copy_done), .BOOT_COPY_REQ(copy_req),
      .FLASH_PROGRAM(prog), .FLASH_PROGRAM_VERIFY(pver), .FLASH_ERASE(ers), .FLASH_ERASE_VERIFY(ever),
      .FLASH_ERASE_BLOCKS(blocks), .FLASH_UNIT_ADDR(unit_addr), .ARRAY_RD_ADDR(rd_addr),
      .ARRAY_RD_DATA(rd_data), .READ_DATA(read_data));

   task automatic wrap_up();
      if (fail_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Values are taken before the edge's own updates land, which is what the edge sampled.
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      wb_sel <= 4'hf;
      @(posedge ref_clk);
      while (ack !== 1'b1) @(posedge ref_clk);
      rdat = dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      xfer(1'b1, adr, dat);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      xfer(1'b0, adr, 32'h0);
      chk(rdat, exp);
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         fail_count++;
         wrap_up();
      end
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd_chk(OFF_MODE_ONE, 32'h00);
      wr(OFF_MODE_ONE, 32'h40);
      rd_chk(OFF_MODE_ONE, 32'h00);
      pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd_chk(OFF_MODE_ONE, 32'h80);
      wr(OFF_MODE_ONE, 32'h70);
      rd_chk(OFF_MODE_ONE, 32'hc0);
      wr(OFF_MODE_ONE, 32'h41);
      wr(OFF_MODE_ONE, 32'h42);
      rd_chk(OFF_MODE_ONE, 32'hc0);
      chk({28'h0, ops}, 32'h0);
      wr(OFF_MODE_TWO, 32'h03);
      wr(OFF_BLK_TWO, 32'h02);
      wr(OFF_PROG_ADDR, 32'h010ff);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_MODE_ONE, {24'h0, modes[i]});
         wr(OFF_MODE_ONE, 32'h4f);
         rd_chk(OFF_MODE_ONE, {24'h0, modes[i] | 8'h80});
         chk({28'h0, ops}, {28'h0, modes[i][3:0]});
         if (modes[i] == 8'h42) begin
            chk({20'h0, blocks}, 32'h002);
         end
         if (modes[i] == 8'h41) begin
            chk({14'h0, unit_addr}, 32'h01080);
         end
         wr(OFF_MODE_ONE, 32'h40);
         rd_chk(OFF_MODE_ONE, 32'hc0);
      end
      // Programming dirtied block one, so erase it again before the erased-read probes.
      wr(OFF_MODE_ONE, 32'h42);
      wr(OFF_MODE_ONE, 32'h40);
      for (int i = 0; i < 4; i++) begin
         rd_addr <= probe[i];
         repeat (2) @(posedge ref_clk);
         chk({24'h0, read_data}, {24'h0, seen[i]});
      end
      wr(OFF_MODE_TWO, 32'h00);
      wr(OFF_BLK_TWO, 32'h00);
      wr(OFF_MODE_ONE, 32'h00);
      wr(OFF_MODE_TWO, 32'h03);
      rd_chk(OFF_MODE_TWO, 32'h00);
      wr(OFF_BLK_TWO, 32'h01);
      rd_chk(OFF_BLK_TWO, 32'h00);
      wr(OFF_MODE_ONE, 32'h48);
      rd_chk(OFF_MODE_ONE, 32'hc0);
      acc_en <= 1'b0;
      wr(OFF_MODE_ONE, 32'h00);
      rd_chk(OFF_MODE_ONE, 32'h00);
      acc_en <= 1'b1;
      rd_chk(OFF_MODE_ONE, 32'hc0);
      rd_chk(8'h20, 32'h00);
      wr(OFF_MODE_ONE, 32'h40);
      wr(OFF_MODE_TWO, 32'h01);
      wr(OFF_MODE_ONE, 32'h41);
      @(posedge ref_clk);
      chk({28'h0, ops}, 32'h1);
      pin <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({28'h0, ops}, 32'h0);
      pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      low_pwr <= 1'b1;
      repeat (2) @(posedge ref_clk);
      low_pwr <= 1'b0;
      rd_chk(OFF_MODE_ONE, 32'h80);
      chk({28'h0, ops}, 32'h0);
      boot <= 1'b1;
      repeat (2) @(posedge ref_clk);
      comm_ok <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk({31'h0, copy_req}, 32'h1);
      chk({20'h0, blocks}, 32'hfff);
      copy_done <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk({31'h0, copy_req}, 32'h0);
      wrap_up();
   end
endmodule
